/* hw/fpxc_pkg.sv */
// Constants and register layout of the floating-point exception control block
`default_nettype none
package fpxc_pkg;
    // Register map
    localparam logic [7:0]  CSR_OFFSET    = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET = 8'h04;
    // Control/status register fields
    localparam int          RM_LSB    = 0;
    localparam int          FLAG_LSB  = 2;
    localparam int          EN_LSB    = 7;
    localparam int          CAUSE_LSB = 12;
    localparam int          FS_BIT    = 24;
    localparam logic [31:0] CSR_RESET = 32'h0000_0000;
    // Exception bit positions inside the cause, enable and flag fields
    localparam int          EXC_I = 0;
    localparam int          EXC_U = 1;
    localparam int          EXC_O = 2;
    localparam int          EXC_Z = 3;
    localparam int          EXC_V = 4;
    localparam int          EXC_E = 5;
    // Rounding modes
    localparam logic [1:0]  ROUND_TO_NEAREST   = 2'h0;
    localparam logic [1:0]  ROUND_TOWARD_ZERO  = 2'h1;
    localparam logic [1:0]  ROUND_TOWARD_PLUS  = 2'h2;
    localparam logic [1:0]  ROUND_TOWARD_MINUS = 2'h3;
    // Operation codes
    localparam logic [3:0]  OP_ADD               = 4'h0;
    localparam logic [3:0]  OP_SUB               = 4'h1;
    localparam logic [3:0]  OP_MUL               = 4'h2;
    localparam logic [3:0]  OP_DIV               = 4'h3;
    localparam logic [3:0]  OP_SQRT              = 4'h4;
    localparam logic [3:0]  OP_CMP               = 4'h5;
    localparam logic [3:0]  OP_CVT_INT           = 4'h6;
    localparam logic [3:0]  OP_CVT_FP            = 4'h7;
    localparam logic [3:0]  ABSOLUTE_VALUE_OP    = 4'h8;
    localparam logic [3:0]  NEGATE_OP            = 4'h9;
    localparam logic [3:0]  REGISTER_MOVE_OP     = 4'hA;
    // CPU exception code for a floating-point trap (value arbitrary)
    localparam logic [4:0]  FP_EXCEPTION_CODE = 5'h0F;
    // Unbiased exponent limits, 13-bit signed
    localparam logic signed [12:0] D_EMAX = 13'sh03FF;
    localparam logic signed [12:0] D_EMIN = -13'sh03FE;
    localparam logic signed [12:0] S_EMAX = 13'sh007F;
    localparam logic signed [12:0] S_EMIN = -13'sh007E;
    // Default result magnitudes
    localparam logic [62:0] D_INF  = 63'h7FF0_0000_0000_0000;
    localparam logic [62:0] D_MAX  = 63'h7FEF_FFFF_FFFF_FFFF;
    localparam logic [62:0] D_MINN = 63'h0010_0000_0000_0000;
    localparam logic [62:0] D_QNAN = 63'h7FF8_0000_0000_0000;
    localparam logic [62:0] D_ZERO = 63'h0000_0000_0000_0000;
    localparam logic [30:0] S_INF  = 31'h7F80_0000;
    localparam logic [30:0] S_MAX  = 31'h7F7F_FFFF;
    localparam logic [30:0] S_MINN = 31'h0080_0000;
    localparam logic [30:0] S_QNAN = 31'h7FC0_0000;
    localparam logic [30:0] S_ZERO = 31'h0000_0000;
    // Pre-screen: biased exponents outside the safe band force a stall
    localparam logic [10:0] D_SAFE_LO = 11'h200;
    localparam logic [10:0] D_SAFE_HI = 11'h600;
    localparam logic [10:0] S_SAFE_LO = 11'h040;
    localparam logic [10:0] S_SAFE_HI = 11'h0C0;
endpackage
`default_nettype wire

/* hw/fpxc_exception_ctl.sv */
// Floating-point exception detection, default results, trap request and control register
//
// The implementer's own choices: the APB slave port and the register addresses.
`default_nettype none

module fpxc_exception_ctl (
    // Clock and reset
    input  wire logic                  SYS_CLK_I,
    input  wire logic                  RESET_I,
    // APB slave
    input  wire logic                  PSEL_I,
    input  wire logic                  PENABLE_I,
    input  wire logic                  PWRITE_I,
    input  wire logic [7:0]            PADDR_I,
    input  wire logic [31:0]           PWDATA_I,
    output logic      [31:0]           PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    // Issue pre-screen
    input  wire logic                  ISSUE_VALID_I,
    input  wire logic                  ISSUE_DBL_I,
    input  wire logic                  ISSUE_MULTI_I,
    input  wire logic [10:0]           ISSUE_EXP_A_I,
    input  wire logic [10:0]           ISSUE_EXP_B_I,
    output logic                       ISSUE_READY_O,
    output logic                       STALL_O,
    // Completed operation from the datapath
    input  wire logic                  OP_VALID_I,
    input  wire logic [3:0]            OP_CODE_I,
    input  wire logic                  OP_DBL_I,
    input  wire logic                  OP_CMP_ORDERED_I,
    input  wire logic [63:0]           OPA_I,
    input  wire logic [63:0]           OPB_I,
    input  wire logic [63:0]           RES_VALUE_I,
    input  wire logic                  RES_SIGN_I,
    input  wire logic                  RES_ZERO_I,
    input  wire logic signed [12:0]    RES_EXP_I,
    input  wire logic                  RES_INEXACT_I,
    input  wire logic                  CVT_RANGE_ERR_I,
    input  wire logic                  UNIMPL_I,
    // Writeback and trap
    output logic                       WB_EN_O,
    output logic      [63:0]           WB_DATA_O,
    output logic                       TRAP_O,
    output logic      [4:0]            EXC_CODE_O
);
    import fpxc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Operand classification
    function automatic logic f_exp_max(input logic dbl, input logic [63:0] x);
        f_exp_max = dbl ? (x[62:52] == 11'h7FF) : (x[30:23] == 8'hFF);
    endfunction

    function automatic logic f_exp_zero(input logic dbl, input logic [63:0] x);
        f_exp_zero = dbl ? (x[62:52] == 11'h000) : (x[30:23] == 8'h00);
    endfunction

    function automatic logic f_frac_zero(input logic dbl, input logic [63:0] x);
        f_frac_zero = dbl ? (x[51:0] == 52'h0) : (x[22:0] == 23'h0);
    endfunction

    function automatic logic f_sign(input logic dbl, input logic [63:0] x);
        f_sign = dbl ? x[63] : x[31];
    endfunction

    function automatic logic f_snan(input logic dbl, input logic [63:0] x);
        f_snan = f_exp_max(dbl, x) && !f_frac_zero(dbl, x) && !(dbl ? x[51] : x[22]);
    endfunction

    function automatic logic [63:0] f_val(input logic dbl, input logic s,
                                          input logic [62:0] dv, input logic [30:0] sv);
        f_val = dbl ? {s, dv} : {32'h0, s, sv};
    endfunction

    function automatic logic f_risky(input logic dbl, input logic [10:0] e);
        if (dbl) begin
            f_risky = (e < D_SAFE_LO) || (e >= D_SAFE_HI);
        end else begin
            f_risky = (e < S_SAFE_LO) || (e >= S_SAFE_HI);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Control/status state
    logic [1:0]  rm_reg;
    logic [4:0]  flag_reg;
    logic [4:0]  en_reg;
    logic [5:0]  cause_reg;
    logic        fs_reg;
    logic        pending_reg;
    logic [4:0]  last_code_reg;
    logic [31:0] prdata_reg;
    logic        csr_wr;
    logic        csr_hit;
    logic        stat_hit;

    assign csr_hit  = (PADDR_I == CSR_OFFSET);
    assign stat_hit = (PADDR_I == STATUS_OFFSET);
    assign csr_wr   = PSEL_I && PENABLE_I && PWRITE_I && csr_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Exception detection
    logic        na, nb, ia, ib, za, zb, sa, sb;
    logic        two_op, is_num, is_wb, is_mov, snan_any;
    logic        inv, dz, chk, ovf, tiny, unf_unimpl, unf, inx, unimpl;
    logic [4:0]  exc5;
    logic [5:0]  exc6;
    logic [4:0]  flag_set;
    logic        trap;
    logic        rs;
    logic [63:0] ovf_val, unf_val, res_w;
    logic signed [12:0] emax, emin;

    assign na = f_exp_max(OP_DBL_I, OPA_I) && !f_frac_zero(OP_DBL_I, OPA_I);
    assign nb = f_exp_max(OP_DBL_I, OPB_I) && !f_frac_zero(OP_DBL_I, OPB_I);
    assign ia = f_exp_max(OP_DBL_I, OPA_I) && f_frac_zero(OP_DBL_I, OPA_I);
    assign ib = f_exp_max(OP_DBL_I, OPB_I) && f_frac_zero(OP_DBL_I, OPB_I);
    assign za = f_exp_zero(OP_DBL_I, OPA_I) && f_frac_zero(OP_DBL_I, OPA_I);
    assign zb = f_exp_zero(OP_DBL_I, OPB_I) && f_frac_zero(OP_DBL_I, OPB_I);
    assign sa = f_sign(OP_DBL_I, OPA_I);
    assign sb = f_sign(OP_DBL_I, OPB_I);

    assign two_op = (OP_CODE_I <= OP_DIV) || (OP_CODE_I == OP_CMP);
    assign is_num = (OP_CODE_I <= OP_SQRT) || (OP_CODE_I == OP_CVT_FP);
    assign is_mov = (OP_CODE_I == REGISTER_MOVE_OP);
    assign is_wb  = (OP_CODE_I != OP_CMP) && (OP_CODE_I <= REGISTER_MOVE_OP);
    assign snan_any = f_snan(OP_DBL_I, OPA_I) || (two_op && f_snan(OP_DBL_I, OPB_I));

    assign emax = OP_DBL_I ? D_EMAX : S_EMAX;
    assign emin = OP_DBL_I ? D_EMIN : S_EMIN;

    always_comb begin
        inv = 1'b0;
        if (!is_mov && snan_any) begin
            inv = 1'b1;
        end
        case (OP_CODE_I)
            OP_ADD:     if (ia && ib && (sa != sb)) inv = 1'b1;
            OP_SUB:     if (ia && ib && (sa == sb)) inv = 1'b1;
            OP_MUL:     if ((za && ib) || (ia && zb)) inv = 1'b1;
            OP_DIV:     if ((za && zb) || (ia && ib)) inv = 1'b1;
            OP_SQRT:    if (sa && !za && !na) inv = 1'b1;
            OP_CMP:     if (OP_CMP_ORDERED_I && (na || nb)) inv = 1'b1;
            OP_CVT_INT: if (CVT_RANGE_ERR_I) inv = 1'b1;
            default:    ;
        endcase
    end

    assign dz   = (OP_CODE_I == OP_DIV) && zb && !za && !ia && !na && !inv;
    assign chk  = is_num && !inv && !dz && !na && !nb && !ia && !ib;
    assign ovf  = chk && !RES_ZERO_I && (RES_EXP_I > emax);
    assign tiny = chk && !RES_ZERO_I && (RES_EXP_I < emin);
    assign unf_unimpl = tiny && (en_reg[EXC_U] || en_reg[EXC_I] || !fs_reg);
    assign unf  = tiny && !unf_unimpl;
    assign inx  = chk && (RES_INEXACT_I || ovf || unf);
    assign unimpl = UNIMPL_I || unf_unimpl;
    assign exc5 = unimpl ? 5'h00 : {inv, dz, ovf, unf, inx};
    assign exc6 = {unimpl, exc5};
    assign trap = unimpl || ((exc5 & en_reg) != 5'h00);
    assign flag_set = OP_VALID_I ? (exc5 & ~en_reg) : 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Default results
    assign rs = RES_SIGN_I;

    always_comb begin
        case (rm_reg)
            ROUND_TO_NEAREST:  ovf_val = f_val(OP_DBL_I, rs, D_INF, S_INF);
            ROUND_TOWARD_ZERO: ovf_val = f_val(OP_DBL_I, rs, D_MAX, S_MAX);
            ROUND_TOWARD_PLUS: begin
                ovf_val = rs ? f_val(OP_DBL_I, 1'b1, D_MAX, S_MAX)
                             : f_val(OP_DBL_I, 1'b0, D_INF, S_INF);
            end
            default: begin
                ovf_val = rs ? f_val(OP_DBL_I, 1'b1, D_INF, S_INF)
                             : f_val(OP_DBL_I, 1'b0, D_MAX, S_MAX);
            end
        endcase
    end

    always_comb begin
        case (rm_reg)
            ROUND_TO_NEAREST,
            ROUND_TOWARD_ZERO: unf_val = f_val(OP_DBL_I, rs, D_ZERO, S_ZERO);
            ROUND_TOWARD_PLUS: begin
                unf_val = rs ? f_val(OP_DBL_I, 1'b1, D_ZERO, S_ZERO)
                             : f_val(OP_DBL_I, 1'b0, D_MINN, S_MINN);
            end
            default: begin
                unf_val = rs ? f_val(OP_DBL_I, 1'b1, D_MINN, S_MINN)
                             : f_val(OP_DBL_I, 1'b0, D_ZERO, S_ZERO);
            end
        endcase
    end

    always_comb begin
        if (inv) begin
            res_w = f_val(OP_DBL_I, 1'b0, D_QNAN, S_QNAN);
        end else if (dz) begin
            res_w = f_val(OP_DBL_I, sa ^ sb, D_INF, S_INF);
        end else if (ovf) begin
            res_w = ovf_val;
        end else if (unf) begin
            res_w = unf_val;
        end else begin
            res_w = RES_VALUE_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Writeback and trap outputs
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            WB_EN_O   <= 1'b0;
            WB_DATA_O <= 64'h0;
        end else begin
            WB_EN_O <= OP_VALID_I && is_wb && !trap;
            if (OP_VALID_I && !trap) begin
                WB_DATA_O <= res_w;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            TRAP_O        <= 1'b0;
            EXC_CODE_O    <= 5'h00;
            last_code_reg <= 5'h00;
        end else begin
            TRAP_O     <= OP_VALID_I && trap;
            EXC_CODE_O <= (OP_VALID_I && trap) ? FP_EXCEPTION_CODE : 5'h00;
            if (OP_VALID_I && trap) begin
                last_code_reg <= FP_EXCEPTION_CODE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Issue pre-screen and stall
    logic issue_take;
    logic issue_risky;

    assign ISSUE_READY_O = !pending_reg;
    assign STALL_O       = pending_reg;
    assign issue_take    = ISSUE_VALID_I && !pending_reg;
    assign issue_risky   = f_risky(ISSUE_DBL_I, ISSUE_EXP_A_I)
                        || f_risky(ISSUE_DBL_I, ISSUE_EXP_B_I)
                        || (ISSUE_MULTI_I && en_reg[EXC_I]);

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            pending_reg <= 1'b0;
        end else if (issue_take && issue_risky) begin
            pending_reg <= 1'b1;
        end else if (OP_VALID_I) begin
            pending_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control/status register
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            rm_reg <= CSR_RESET[RM_LSB +: 2];
            en_reg <= CSR_RESET[EN_LSB +: 5];
            fs_reg <= CSR_RESET[FS_BIT];
        end else if (csr_wr) begin
            rm_reg <= PWDATA_I[RM_LSB +: 2];
            en_reg <= PWDATA_I[EN_LSB +: 5];
            fs_reg <= PWDATA_I[FS_BIT];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            flag_reg <= CSR_RESET[FLAG_LSB +: 5];
        end else begin
            flag_reg <= (csr_wr ? PWDATA_I[FLAG_LSB +: 5] : flag_reg) | flag_set;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            cause_reg <= CSR_RESET[CAUSE_LSB +: 6];
        end else if (OP_VALID_I) begin
            cause_reg <= exc6;
        end else if (csr_wr) begin
            cause_reg <= PWDATA_I[CAUSE_LSB +: 6];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB read path, data captured in the setup cycle
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            prdata_reg <= 32'h0;
        end else if (PSEL_I && !PENABLE_I) begin
            if (csr_hit) begin
                prdata_reg <= {7'h00, fs_reg, 6'h00, cause_reg, en_reg, flag_reg, rm_reg};
            end else if (stat_hit) begin
                prdata_reg <= {21'h0, last_code_reg, 5'h00, pending_reg};
            end else begin
                prdata_reg <= 32'h0;
            end
        end
    end

    assign PRDATA_O  = prdata_reg;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !csr_hit && !stat_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    AST_CAUSE_SET: assert property (
        OP_VALID_I && inv && !unimpl |=> cause_reg[EXC_V])
        else $error("invalid cause bit not set");

    AST_FLAG_SET: assert property (
        (flag_set != 5'h00) |=> ((flag_reg & $past(flag_set)) == $past(flag_set)))
        else $error("flag not set for untrapped exception");

    AST_UNIMPL_TRAP: assert property (
        OP_VALID_I && unimpl |=> TRAP_O && cause_reg[EXC_E] && !WB_EN_O)
        else $error("unimplemented exception did not trap");

    AST_TRAP_NO_WB: assert property (
        TRAP_O |-> !WB_EN_O && $stable(WB_DATA_O))
        else $error("destination changed on trap");

    AST_FPE_CODE: assert property (
        TRAP_O |-> EXC_CODE_O == FP_EXCEPTION_CODE)
        else $error("wrong exception code on trap");

    AST_FLAG_STICKY: assert property (
        !csr_wr |=> (($past(flag_reg) & ~flag_reg) == 5'h00))
        else $error("flag cleared without software write");

    AST_OVF_INEXACT: assert property (
        OP_VALID_I && ovf && !unimpl |=> cause_reg[EXC_O] && cause_reg[EXC_I])
        else $error("overflow without inexact");

    AST_DZ_INF: assert property (
        OP_VALID_I && dz && !trap && rm_reg == ROUND_TO_NEAREST
        |=> WB_EN_O && cause_reg[EXC_Z]
            && WB_DATA_O == f_val($past(OP_DBL_I), $past(sa) ^ $past(sb), D_INF, S_INF))
        else $error("divide by zero default result missing");

    AST_STALL_ONE: assert property (
        issue_take && issue_risky |=> STALL_O && !ISSUE_READY_O)
        else $error("risky issue not stalled");

    AST_QNAN: assert property (
        OP_VALID_I && inv && !trap && is_wb && OP_DBL_I
        |=> WB_EN_O && WB_DATA_O == 64'h7FF8_0000_0000_0000)
        else $error("invalid default not quiet NaN");
endmodule
`default_nettype wire

/* verification/fpxc_cpu_model.sv */
// Integer CPU side model driving the issue pre-screen handshake
`default_nettype none
module fpxc_cpu_model (
    // Clock
    input  wire logic        clk_i,
    // Issue handshake
    input  wire logic        ready_i,
    output logic             valid_o,
    output logic             dbl_o,
    output logic             multi_o,
    output logic [10:0]      exp_a_o,
    output logic [10:0]      exp_b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        valid_o = 1'b0;
        dbl_o = 1'b0;
        multi_o = 1'b0;
        exp_a_o = 11'h000;
        exp_b_o = 11'h000;
    end
    // Request held until taken, then released exponent lines show the inverse
    task automatic issue(input logic d, input logic m, input logic [10:0] a,
                         input logic [10:0] b);
        @(posedge clk_i);
        valid_o <= 1'b1;
        dbl_o <= d;
        multi_o <= m;
        exp_a_o <= a;
        exp_b_o <= b;
        do @(posedge clk_i); while (ready_i !== 1'b1);
        valid_o <= 1'b0;
        exp_a_o <= ~a;
        exp_b_o <= ~b;
    endtask
endmodule
`default_nettype wire

/* verification/tb_fpxc_exception_ctl.sv */
// Self-checking bench for the floating-point exception control block
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_fpxc_exception_ctl import fpxc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] ONE = 64'h3FF0_0000_0000_0000;
    localparam logic [63:0] INF = 64'h7FF0_0000_0000_0000;
    localparam logic [63:0] SNAN = 64'h7FF4_0000_0000_0000;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  paddr = 8'h00, rnd = 8'h4E;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irdy, stall, wb, trap, iv, idbl, imul, er;
    logic [10:0] iea, ieb;
    logic        opv = 1'b0, cmpo = 1'b0, rs = 1'b0, ri = 1'b0, un = 1'b0;
    logic        dbl = 1'b1, cvr = 1'b0;
    logic [3:0]  opc = 4'h0;
    logic [63:0] opa = 64'h0, opb = 64'h0, rv = 64'h0, wbd, v;
    logic signed [12:0] re = 13'sh0000;
    logic [4:0]  code;
    logic [69:0] q[$];
    logic [69:0] qe;
    int          err_total = 0, checks_done = 0, cyc = 0;
    logic [3:0]  vc[8] = '{OP_MUL, OP_DIV, OP_DIV, OP_SQRT, ABSOLUTE_VALUE_OP, NEGATE_OP,
                           OP_SUB, OP_ADD};
    logic [63:0] va[8] = '{64'h0, 64'h0, INF, 64'hBFF0_0000_0000_0000, SNAN, SNAN, INF, ONE};
    logic [63:0] vb[8] = '{INF, 64'h0, INF, 64'h0, 64'h0, 64'h0, INF, SNAN};

    fpxc_exception_ctl i_fpxc_exception_ctl (
        .SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .ISSUE_VALID_I(iv), .ISSUE_DBL_I(idbl), .ISSUE_MULTI_I(imul),
        .ISSUE_EXP_A_I(iea), .ISSUE_EXP_B_I(ieb), .ISSUE_READY_O(irdy), .STALL_O(stall),
        .OP_VALID_I(opv), .OP_CODE_I(opc), .OP_DBL_I(dbl), .OP_CMP_ORDERED_I(cmpo),
        .OPA_I(opa), .OPB_I(opb), .RES_VALUE_I(rv), .RES_SIGN_I(rs), .RES_ZERO_I(1'b0),
        .RES_EXP_I(re), .RES_INEXACT_I(ri), .CVT_RANGE_ERR_I(cvr), .UNIMPL_I(un),
        .WB_EN_O(wb), .WB_DATA_O(wbd), .TRAP_O(trap), .EXC_CODE_O(code));
    fpxc_cpu_model i_fpxc_cpu_model (
        .clk_i(clk), .ready_i(irdy), .valid_o(iv), .dbl_o(idbl), .multi_o(imul),
        .exp_a_o(iea), .exp_b_o(ieb));

    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            close_out();
        end
    end
    // Result monitor against the oldest noted expectation, mid-cycle
    always @(negedge clk) begin
        if (wb || trap) begin
            if (q.size() == 0) begin
                err_total++;
                $display("BAD %0t result with nothing expected", $time);
            end else begin
                qe = q.pop_front();
                `CHK({trap, code, wb ? wbd : 64'h0}, qe)
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [63:0] ovf(input logic [1:0] m, input logic s);
        if (m == ROUND_TO_NEAREST || (m == ROUND_TOWARD_PLUS && !s) ||
            (m == ROUND_TOWARD_MINUS && s)) return {s, D_INF};
        return {s, D_MAX};
    endfunction
    function automatic logic [63:0] unf(input logic [1:0] m, input logic s);
        if ((m == ROUND_TOWARD_PLUS && !s) || (m == ROUND_TOWARD_MINUS && s)) return {s, D_MINN};
        return {s, D_ZERO};
    endfunction
    task automatic ew(input logic [63:0] d);
        q.push_back({6'h00, d});
    endtask
    task automatic et();
        q.push_back({1'b1, FP_EXCEPTION_CODE, 64'h0});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic csr_wr(input logic [31:0] d);
        apb(1'b1, CSR_OFFSET, d, rd, er);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rd, er);
        `CHK(rd, x)
    endtask
    task automatic op(input logic [3:0] c, input logic [63:0] a, b, r,
                      input logic signed [12:0] ex, input logic s, i, u);
        @(posedge clk);
        opv <= 1'b1;
        opc <= c;
        opa <= a;
        opb <= b;
        rv <= r;
        re <= ex;
        rs <= s;
        ri <= i;
        un <= u;
        @(posedge clk);
        opv <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk_rd(CSR_OFFSET, CSR_RESET);
        chk_rd(STATUS_OFFSET, 32'h0);
        apb(1'b0, 8'h08, 32'h0, rd, er);
        `CHK(er, 1'b1)
        $display("done reset and map");
        ew({1'b1, D_INF});
        op(OP_DIV, ONE, 64'h8000_0000_0000_0000, 64'h0, 13'sh0000, 1'b1, 1'b0, 1'b0);
        chk_rd(CSR_OFFSET, 32'h0000_8020);
        rnd = lfsr(rnd);
        v = {12'h400, {6{rnd}}, 4'h1};
        ew(v);
        op(OP_ADD, ONE, ONE, v, 13'sh0001, 1'b0, 1'b1, 1'b0);
        chk_rd(CSR_OFFSET, 32'h0000_1024);
        csr_wr(32'h0000_0420);
        et();
        op(OP_DIV, ONE, 64'h0, 64'h0, 13'sh0000, 1'b0, 1'b0, 1'b0);
        chk_rd(CSR_OFFSET, 32'h0000_8420);
        chk_rd(STATUS_OFFSET, 32'h0000_03C0);
        $display("done divide by zero");
        for (int k = 0; k < 16; k++) begin
            csr_wr({7'h00, k[3], 22'h0, k[2:1]});
            ew(k[3] ? unf(k[2:1], k[0]) : ovf(k[2:1], k[0]));
            op(OP_MUL, ONE, ONE, ONE, k[3] ? -13'sh044C : 13'sh0400, k[0], 1'b1, 1'b0);
            if (k == 7) chk_rd(CSR_OFFSET, 32'h0000_5017);
        end
        chk_rd(CSR_OFFSET, 32'h0100_300F);
        csr_wr(32'h0);
        et();
        op(OP_MUL, ONE, ONE, ONE, -13'sh044C, 1'b0, 1'b1, 1'b0);
        chk_rd(CSR_OFFSET, 32'h0002_0000);
        et();
        op(OP_ADD, ONE, ONE, ONE, 13'sh0000, 1'b0, 1'b0, 1'b1);
        $display("done overflow underflow");
        csr_wr(32'h0);
        for (int k = 0; k < 8; k++) begin
            ew({1'b0, D_QNAN});
            op(vc[k], va[k], vb[k], ONE, 13'sh0000, 1'b0, 1'b0, 1'b0);
        end
        chk_rd(CSR_OFFSET, 32'h0001_0040);
        ew(SNAN);
        op(REGISTER_MOVE_OP, SNAN, 64'h0, SNAN, 13'sh0000, 1'b0, 1'b0, 1'b0);
        chk_rd(CSR_OFFSET, 32'h0000_0040);
        cvr <= 1'b1;
        ew({1'b0, D_QNAN});
        op(OP_CVT_INT, ONE, 64'h0, ONE, 13'sh0000, 1'b0, 1'b0, 1'b0);
        cvr <= 1'b0;
        dbl <= 1'b0;
        ew({33'h0, S_QNAN});
        op(OP_SQRT, 64'hBF80_0000, 64'h0, ONE, 13'sh0000, 1'b0, 1'b0, 1'b0);
        dbl <= 1'b1;
        csr_wr(32'h0000_0800);
        cmpo <= 1'b1;
        et();
        op(OP_CMP, {1'b0, D_QNAN}, ONE, 64'h0, 13'sh0000, 1'b0, 1'b0, 1'b0);
        cmpo <= 1'b0;
        $display("done invalid");
        csr_wr(32'h0);
        i_fpxc_cpu_model.issue(1'b1, 1'b0, 11'h7FF, 11'h3FF);
        @(negedge clk);
        `CHK({stall, irdy}, 2'b10)
        ew(ONE);
        op(OP_ADD, ONE, ONE, ONE, 13'sh0000, 1'b0, 1'b0, 1'b0);
        @(negedge clk);
        `CHK({stall, irdy}, 2'b01)
        csr_wr(32'h0000_0080);
        i_fpxc_cpu_model.issue(1'b1, 1'b1, 11'h3FF, 11'h3FF);
        @(negedge clk);
        `CHK({stall, irdy}, 2'b10)
        ew(ONE);
        op(OP_ADD, ONE, ONE, ONE, 13'sh0000, 1'b0, 1'b0, 1'b0);
        i_fpxc_cpu_model.issue(1'b1, 1'b0, 11'h3FF, 11'h3FF);
        @(negedge clk);
        `CHK({stall, irdy}, 2'b01)
        `CHK(q.size(), 0)
        $display("done stall");
        close_out();
    end
endmodule
`default_nettype wire
